// [src/service_request_status.sv]
// status summary, service request and serial poll logic of an instrument
// Function
// - trigger enable survives clear-status
// - status bit 6 summarises enabled bits
// - enabled event asserts service request line
// - serial poll returns one status byte
// - requester shows request bit in poll
// - poll releases line, status stays latched
// - preset zeroes operation and questionable enable registers, request enable kept
// - enable value 32 enables trigger wait
// - request enable 128 asserts on trigger wait
`timescale 1ns/1ps
module service_request_status
  import srq_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_wait_trig,
  input  wire logic [srq_pkg::OPER_W-1:0]  i_ques_cond,
  input  wire logic                        i_oper_en_wr,
  input  wire logic                        i_ques_en_wr,
  input  wire logic                        i_sre_wr,
  input  wire logic [srq_pkg::OPER_W-1:0]  i_wr_data,
  input  wire logic                        i_preset,
  input  wire logic                        i_clear,
  input  wire logic                        i_spoll,
  output logic                             o_srq_out,
  output logic                             o_srq_oe_n,
  output logic [srq_pkg::BYTE_W-1:0]       o_poll_byte,
  output logic                             o_poll_valid,
  output logic [srq_pkg::BYTE_W-1:0]       o_stb,
  output logic [srq_pkg::OPER_W-1:0]       o_oper_en
);
  import srq_pkg::*;

  logic [OPER_W-1:0] oper_en_reg;
  logic [OPER_W-1:0] oper_en_next;
  logic [OPER_W-1:0] ques_en_reg;
  logic [OPER_W-1:0] ques_en_next;
  logic [BYTE_W-1:0] sre_reg;
  logic [BYTE_W-1:0] sre_next;
  logic [OPER_W-1:0] oper_evt_reg;
  logic [OPER_W-1:0] oper_evt_next;
  logic [OPER_W-1:0] ques_evt_reg;
  logic [OPER_W-1:0] ques_evt_next;
  logic              srq_reg;
  logic              srq_next;
  logic              armed_reg;
  logic              armed_next;
  logic              wt_prev_reg;
  logic              wt_prev_next;
  logic [OPER_W-1:0] qc_prev_reg;
  logic [OPER_W-1:0] qc_prev_next;
  logic [BYTE_W-1:0] stb_reg;
  logic [BYTE_W-1:0] stb_next;
  logic [BYTE_W-1:0] pbyte_reg;
  logic [BYTE_W-1:0] pbyte_next;
  logic              pvalid_reg;
  logic              pvalid_next;
  poll_state_t       pst_reg;
  poll_state_t       pst_next;
  logic [OPER_W-1:0] oper_set;
  logic [OPER_W-1:0] ques_set;
  logic [BYTE_W-1:0] stb_sum;
  logic              new_evt;
  logic              wt_now;

  sync_if trig_sync ();

  assign trig_sync.raw = i_wait_trig;

  // the trigger-wait condition comes from another clock area, so filter it
  pin_sync u_trig_sync
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .port    (trig_sync)
  );

  assign wt_now = trig_sync.level;

  // rising-edge event detection on conditions
  always_comb
  begin
    oper_set                = '0;
    oper_set[OPER_WTRIG]    = wt_now & ~wt_prev_reg;
    ques_set                = i_ques_cond & ~qc_prev_reg;
    wt_prev_next            = wt_now;
    qc_prev_next            = i_ques_cond;
  end

  // enable registers: clear-status leaves them alone on purpose
  always_comb
  begin
    oper_en_next = oper_en_reg;
    ques_en_next = ques_en_reg;
    sre_next     = sre_reg;
    if (i_preset)
    begin
      oper_en_next = OPER_EN_RST;
      ques_en_next = QUES_EN_RST;
    end
    else
    begin
      if (i_oper_en_wr)
      begin
        oper_en_next = i_wr_data;
      end
      if (i_ques_en_wr)
      begin
        ques_en_next = i_wr_data;
      end
    end
    if (i_sre_wr)
    begin
      sre_next = i_wr_data[BYTE_W-1:0];
    end
  end

  // latched event registers; a new event beats a clear in the same cycle
  always_comb
  begin
    oper_evt_next = oper_evt_reg;
    ques_evt_next = ques_evt_reg;
    if (i_clear || i_preset)
    begin
      oper_evt_next = EVT_RST;
      ques_evt_next = EVT_RST;
    end
    oper_evt_next = oper_evt_next | oper_set;
    ques_evt_next = ques_evt_next | ques_set;
  end

  // status byte summary built from the next event state
  always_comb
  begin
    stb_sum           = '0;
    stb_sum[STB_OPER] = |(oper_evt_next & oper_en_next);
    stb_sum[STB_QUES] = |(ques_evt_next & ques_en_next);
    stb_sum[STB_RQS]  = |(stb_sum & sre_next & ~(8'h01 << STB_RQS));
    stb_next          = stb_sum;
  end

  // a request fires only on a freshly enabled event, not on a stale latch
  assign new_evt = |(oper_set & oper_en_reg) | |(ques_set & ques_en_reg);

  // service request line and serial poll sequencing
  always_comb
  begin
    srq_next    = srq_reg;
    armed_next  = armed_reg;
    pst_next    = pst_reg;
    pbyte_next  = pbyte_reg;
    pvalid_next = 1'b0;
    case (pst_reg)
      POLL_IDLE:
      begin
        if (i_spoll)
        begin
          pst_next = POLL_SEND;
        end
      end
      POLL_SEND:
      begin
        pbyte_next          = stb_reg;
        pbyte_next[STB_RQS] = srq_reg;
        pvalid_next         = 1'b1;
        srq_next            = 1'b0;
        armed_next          = 1'b0;
        pst_next            = POLL_DONE;
      end
      POLL_DONE:
      begin
        if (!i_spoll)
        begin
          pst_next = POLL_IDLE;
        end
      end
      default:
      begin
        pst_next = POLL_IDLE;
      end
    endcase
    if (new_evt)
    begin
      armed_next = 1'b1;
    end
    if (armed_next && stb_next[STB_RQS] && pst_reg != POLL_SEND)
    begin
      srq_next = 1'b1;
    end
    if (i_clear || i_preset)
    begin
      armed_next = new_evt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      oper_en_reg  <= OPER_EN_RST;
      ques_en_reg  <= QUES_EN_RST;
      sre_reg      <= SRE_RST;
      oper_evt_reg <= EVT_RST;
      ques_evt_reg <= EVT_RST;
      srq_reg      <= 1'b0;
      armed_reg    <= 1'b0;
      wt_prev_reg  <= 1'b0;
      qc_prev_reg  <= '0;
      stb_reg      <= '0;
      pbyte_reg    <= '0;
      pvalid_reg   <= 1'b0;
      pst_reg      <= POLL_IDLE;
    end
    else
    begin
      oper_en_reg  <= oper_en_next;
      ques_en_reg  <= ques_en_next;
      sre_reg      <= sre_next;
      oper_evt_reg <= oper_evt_next;
      ques_evt_reg <= ques_evt_next;
      srq_reg      <= srq_next;
      armed_reg    <= armed_next;
      wt_prev_reg  <= wt_prev_next;
      qc_prev_reg  <= qc_prev_next;
      stb_reg      <= stb_next;
      pbyte_reg    <= pbyte_next;
      pvalid_reg   <= pvalid_next;
      pst_reg      <= pst_next;
    end
  end

  // open-drain line: drive low (enable low) while requesting
  assign o_srq_out    = 1'b0;
  assign o_srq_oe_n   = ~srq_reg;
  assign o_poll_byte  = pbyte_reg;
  assign o_poll_valid = pvalid_reg;
  assign o_stb        = stb_reg;
  assign o_oper_en    = oper_en_reg;
endmodule // service_request_status

// [common/srq_pkg.sv]
// shared constants and types for the service request status block
package srq_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          OPER_W        = 16;
  localparam logic [3:0]  OPER_WTRIG    = 4'h5;   // waiting-for-trigger bit position
  localparam logic [2:0]  STB_RQS       = 3'h6;   // request-service bit
  localparam logic [2:0]  STB_QUES      = 3'h3;   // questionable summary bit
  localparam logic [2:0]  STB_OPER      = 3'h7;   // operation summary bit
  localparam logic [15:0] OPER_EN_RST   = 16'h0000;
  localparam logic [15:0] QUES_EN_RST   = 16'h0000;
  localparam logic [7:0]  SRE_RST       = 8'h00;
  localparam logic [15:0] EVT_RST       = 16'h0000;
  localparam int          SYNC_STAGES   = 3;
  // poll sequencing
  typedef enum logic [1:0] {
    POLL_IDLE  = 2'b00,
    POLL_SEND  = 2'b01,
    POLL_DONE  = 2'b11
  } poll_state_t;
endpackage

// [common/sync_if.sv]
// carrier between the top and its input synchroniser
`timescale 1ns/1ps
interface sync_if;
  logic raw;
  logic level;
  modport owner (output raw, input level);
  modport sync  (input raw, output level);
endinterface

// [src/pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync
  import srq_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  sync_if.sync      port
);
  logic [SYNC_STAGES-1:0] sh_reg;
  logic [SYNC_STAGES-1:0] sh_next;
  logic                   lvl_reg;
  logic                   lvl_next;

  // stage 0 feeds only stage 1; level changes once stages 1 and 2 agree
  always_comb
  begin
    sh_next   = {sh_reg[SYNC_STAGES-2:0], port.raw};
    lvl_next  = lvl_reg;
    if (sh_reg[1] == sh_reg[2])
    begin
      lvl_next = sh_reg[2];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sh_reg   <= '0;
      lvl_reg  <= 1'b0;
    end
    else
    begin
      sh_reg   <= sh_next;
      lvl_reg  <= lvl_next;
    end
  end

  assign port.level = lvl_reg;
endmodule // pin_sync

// [bench/srq_sva.sv]
// assertions on the ports of the service request status block
`timescale 1ns/1ps
module srq_sva
  import srq_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_spoll,
  input wire logic              i_preset,
  input wire logic              i_clear,
  input wire logic              i_oper_en_wr,
  input wire logic [OPER_W-1:0] i_wr_data,
  input wire logic              o_srq_oe_n,
  input wire logic [7:0]        o_poll_byte,
  input wire logic              o_poll_valid,
  input wire logic [7:0]        o_stb,
  input wire logic [OPER_W-1:0] o_oper_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // a fresh poll request after the line was low for a cycle
  sequence s_poll;
    $rose(i_spoll);
  endsequence
  sequence s_answer;
    ##2 o_poll_valid ##1 !o_poll_valid;
  endsequence
  a_poll_answer: assert property (s_poll |-> s_answer)
    else $error("poll not answered with one byte");
  a_poll_release: assert property (o_poll_valid |-> o_srq_oe_n)
    else $error("request line held after poll");
  a_req_bit: assert property (o_poll_valid && $past(o_srq_oe_n, 2) == 1'b0
    |-> o_poll_byte[6])
    else $error("requester byte lacks request bit");
  a_srq_rqs: assert property ($fell(o_srq_oe_n) |-> o_stb[6])
    else $error("request line without request bit");
  a_rqs_sum: assert property (o_stb[6] |-> (o_stb[7] || o_stb[3]))
    else $error("request bit without summary bit");
  a_preset_zero: assert property (i_preset |=> o_oper_en == 16'h0000)
    else $error("preset left enable set");
  a_en_write: assert property (i_oper_en_wr && !i_preset
    |=> o_oper_en == $past(i_wr_data))
    else $error("enable write lost");
  a_en_keep: assert property (i_clear && !i_oper_en_wr && !i_preset
    |=> $stable(o_oper_en))
    else $error("clear changed enable");
endmodule // srq_sva

bind service_request_status srq_sva u_sva (.*);

// [bench/ctrl_model.sv]
// bus controller model: serial polls when the request line is pulled
`timescale 1ns/1ps
module ctrl_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_srq_oe_n,
  input  wire logic       i_go,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_byte,
  output logic            o_spoll,
  output logic [7:0]      o_got,
  output logic [7:0]      o_polls
);
  logic [1:0] wt;
  logic       pend;
  // random wait models a slow host; poll held until answered
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_spoll <= 1'b0;
      o_got <= 8'h00;
      o_polls <= 8'h00;
      wt <= 2'd0;
      pend <= 1'b0;
    end
    else if (o_spoll)
    begin
      if (i_valid)
      begin
        o_spoll <= 1'b0;
        o_got <= i_byte;
        o_polls <= o_polls + 8'h01;
      end
    end
    else
    begin
      if (i_go)
        pend <= 1'b1;
      if (!i_srq_oe_n || pend)
        if (wt != 2'd0)
          wt <= wt - 2'd1;
        else
        begin
          o_spoll <= 1'b1;
          pend <= 1'b0;
          wt <= 2'($urandom);
        end
    end
endmodule // ctrl_model

// [bench/tb_top.sv]
// self-checking bench for the service request status block
`timescale 1ns/1ps
module tb_top;
  import srq_pkg::*;
  logic clk = 0, rst_n = 0, wtrig = 0, go = 0, spoll, pvalid, srq_oe_n, srq_out;
  logic preset = 0, oen_wr = 0, qen_wr = 0, sre_wr = 0, clr = 0;
  logic [15:0] qc = 0, wd = 0, oen, d;
  logic [7:0]  pbyte, stb, got, polls;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  service_request_status uut (.i_clk(clk), .i_rst_n(rst_n), .i_wait_trig(wtrig),
    .i_ques_cond(qc), .i_oper_en_wr(oen_wr), .i_ques_en_wr(qen_wr), .i_sre_wr(sre_wr),
    .i_wr_data(wd), .i_preset(preset), .i_clear(clr), .i_spoll(spoll), .o_srq_out(srq_out),
    .o_srq_oe_n(srq_oe_n), .o_poll_byte(pbyte), .o_poll_valid(pvalid), .o_stb(stb),
    .o_oper_en(oen));
  ctrl_model host (.i_clk(clk), .i_rst_n(rst_n), .i_srq_oe_n(srq_oe_n), .i_go(go),
    .i_valid(pvalid), .i_byte(pbyte), .o_spoll(spoll), .o_got(got), .o_polls(polls));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // k picks preset, oper enable, ques enable, request enable, clear
  task automatic pulse(input int k, input logic [15:0] v);
    wd <= v;
    {preset, oen_wr, qen_wr, sre_wr, clr} <= 5'(5'b10000 >> k);
    @(posedge clk);
    {preset, oen_wr, qen_wr, sre_wr, clr} <= 5'b00000;
    @(posedge clk);
  endtask
  task automatic poll_wait(logic [7:0] e);
    logic [7:0] p;
    p = polls;
    repeat (40)
    begin
      if (polls != p)
        break;
      @(posedge clk);
    end
    chk("poll count", 16'(p + 8'h01), 16'(polls));
    chk("poll byte", 16'(e), 16'(got));
  endtask
  // expected status byte: summaries first, then the request bit over enabled ones
  function automatic logic [7:0] exp_stb(logic oper, logic ques, logic [7:0] sre);
    logic [7:0] s;
    s           = 8'h00;
    s[STB_OPER] = oper;
    s[STB_QUES] = ques;
    s[STB_RQS]  = |(s & sre);
    return s;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well past the roughly 130 cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(14145));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("srq oe_n", 1, 16'(srq_oe_n));
    chk("srq out", 0, 16'(srq_out));
    // enabled trigger wait raises request, poll answers and releases
    pulse(0, 0);
    pulse(1, 16'h0020);
    chk("oper en", 16'h0020, oen);
    pulse(3, 16'h0080);
    wtrig <= 1;
    poll_wait(exp_stb(1'b1, 1'b0, 8'h80));
    repeat (10) @(posedge clk);
    chk("srq oe_n", 1, 16'(srq_oe_n));
    chk("stb", 16'(exp_stb(1'b1, 1'b0, 8'h80)), 16'(stb));
    pulse(4, 0);
    chk("stb", 0, 16'(stb));
    chk("oper en", 16'h0020, oen);
    wtrig <= 0;
    repeat (8) @(posedge clk);
    wtrig <= 1;
    poll_wait(exp_stb(1'b1, 1'b0, 8'h80));
    pulse(4, 0);
    // random operation enable values, then preset zeroes the operation enable
    repeat (8)
    begin
      d = 16'($urandom);
      pulse(1, d);
      chk("oper en", d, oen);
    end
    pulse(0, 0);
    chk("oper en", 0, oen);
    wtrig <= 0;
    repeat (8) @(posedge clk);
    wtrig <= 1;
    repeat (20) @(posedge clk);
    chk("srq oe_n", 1, 16'(srq_oe_n));
    // questionable event reaches the request through bit 3
    pulse(2, 16'hffff);
    pulse(3, 16'h0008);
    qc <= 16'($urandom) | 16'h0001;
    poll_wait(exp_stb(1'b0, 1'b1, 8'h08));
    pulse(4, 0);
    qc <= 0;
    // host polls with no request pending
    go <= 1;
    @(posedge clk);
    go <= 0;
    poll_wait(exp_stb(1'b0, 1'b0, 8'h08));
    chk("srq oe_n", 1, 16'(srq_oe_n));
    end_sim();
  end
endmodule // tb_top
